// ---- verilog/lpst_pkg.sv ----
// Shared constants for the pixel serializer transmitter
package lpst_pkg;
  // Clock and timing
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned CLK_NS = 50;
  localparam int unsigned LOCK_MS = 10;
  localparam int unsigned LOCK_CYC = (CLK_HZ / 1000) * LOCK_MS;
  localparam int unsigned PDD_NS = 100;
  localparam int unsigned PDD_CYC = (PDD_NS / CLK_NS < 1) ? 1 : PDD_NS / CLK_NS;
  localparam int unsigned LOCK_W = 18;
  // Word and lane geometry
  localparam int unsigned NBITS = 21;
  localparam int unsigned NLANES = 3;
  localparam int unsigned NSLOTS = 7;
  localparam int unsigned COLOR_W = 6;
  localparam logic [2:0] LAST_SLOT = 3'h6;
  localparam logic [8:0] SLOT_STEP = 9'h007;
  localparam int unsigned PER_W = 8;
  // Word field positions: red, green, blue, then the three controls
  localparam int unsigned RED_LSB = 0;
  localparam int unsigned GREEN_LSB = 6;
  localparam int unsigned BLUE_LSB = 12;
  localparam int unsigned LSYNC_POS = 18;
  localparam int unsigned FSYNC_POS = 19;
  localparam int unsigned VALID_POS = 20;
  // Forwarded clock shape over the seven slots, slot 0 in bit 0
  localparam logic [6:0] CLK_PATTERN = 7'h63;
  // Reset values
  localparam logic [20:0] WORD_RST = 21'h000000;
  localparam logic [2:0] SYNC_RST = 3'h0;
endpackage

// ---- verilog/lpst_lane_if.sv ----
// Carrier between the capture controller and the lane serializer
`timescale 1ns/100ps
`default_nettype none
interface lpst_lane_if;
  logic clear;
  logic load;
  logic [20:0] word;
  logic slot_en;
  logic [2:0] lanes;
  logic clk_lane;
  modport ctrl (output clear, output load, output word, output slot_en,
                input lanes, input clk_lane);
  modport ser (input clear, input load, input word, input slot_en,
               output lanes, output clk_lane);
endinterface
`default_nettype wire

// ---- verilog/lpst_lane_ser.sv ----
// Seven-slot serializer for the three data lanes and the forwarded clock
`timescale 1ns/100ps
`default_nettype none
module lpst_lane_ser (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Link to controller
  lpst_lane_if.ser lk
);
  typedef struct packed {
    logic [20:0] word_q;
    logic [2:0] slot_q;
    logic [2:0] lanes_q;
    logic clk_q;
  } lpst_ser_t;

  lpst_ser_t q;
  lpst_ser_t d;

  // Fixed mapping: lane L, slot S carries word bit L*7+S
  function automatic logic [2:0] lpst_pick(input logic [20:0] w, input logic [2:0] s);
    logic [2:0] r;
    r = 3'h0;
    for (int l = 0; l < 3; l++) begin
      r[l] = w[l * 7 + int'(s)];
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next state: clear wins, then a new word, then the next slot
  always_comb begin
    d = q;
    if (lk.clear) begin
      d = '0;
    end else if (lk.load) begin
      d.word_q = lk.word;
      d.slot_q = 3'h0;
      d.lanes_q = lpst_pick(lk.word, 3'h0);
      d.clk_q = lpst_pkg::CLK_PATTERN[0];
    end else if (lk.slot_en && q.slot_q < lpst_pkg::LAST_SLOT) begin
      d.slot_q = q.slot_q + 3'h1;
      d.lanes_q = lpst_pick(q.word_q, d.slot_q);
      d.clk_q = lpst_pkg::CLK_PATTERN[d.slot_q];
    end
  end

  // State register
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign lk.lanes = q.lanes_q;
  assign lk.clk_lane = q.clk_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_load_word;
    @(posedge clk_i) disable iff (!nrst_i)
    lk.load && !lk.clear |=> q.word_q == $past(lk.word) && q.slot_q == 3'h0
      && q.lanes_q == {$past(lk.word[14]), $past(lk.word[7]), $past(lk.word[0])};
  endproperty
  a_load_word: assert property (p_load_word) else $error("word not loaded at slot 0");

  property p_slot_step;
    @(posedge clk_i) disable iff (!nrst_i)
    lk.slot_en && !lk.load && !lk.clear && q.slot_q < 3'h6 |=> q.slot_q == $past(q.slot_q) + 3'h1;
  endproperty
  a_slot_step: assert property (p_slot_step) else $error("slot did not advance");

  property p_clk_shape;
    @(posedge clk_i) disable iff (!nrst_i)
    lk.load && !lk.clear |=> q.clk_q ##1 (q.clk_q || q.slot_q != 3'h2) [*1];
  endproperty
  a_clk_shape: assert property (p_clk_shape) else $error("forwarded clock shape wrong");
endmodule
`default_nettype wire

// ---- verilog/lpst_top.sv ----
// Pixel serializer transmitter: capture, slot timing, lock and power-down
`timescale 1ns/100ps
`default_nettype none
module lpst_top #(
  parameter int unsigned LOCK_CYCLES = lpst_pkg::LOCK_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Parallel pixel inputs from the controller
  input wire logic pixel_clock_in_i,
  input wire logic [5:0] red_i,
  input wire logic [5:0] green_i,
  input wire logic [5:0] blue_i,
  input wire logic line_sync_i,
  input wire logic frame_sync_i,
  input wire logic pixel_valid_i,
  // Configuration and power control
  input wire logic strobe_edge_select_i,
  input wire logic sleep_n_i,
  // Serial lanes
  output logic [2:0] serial_lane_p_o,
  output logic [2:0] serial_lane_n_o,
  output logic [2:0] serial_lane_oe_o,
  // Forwarded clock pair
  output logic forwarded_clock_p_o,
  output logic forwarded_clock_n_o,
  output logic forwarded_clock_oe_o,
  // Status
  output logic locked_o
);
  typedef struct packed {
    logic [2:0] clk_s;
    logic [2:0] sel_s;
    logic [2:0] slp_s;
    logic [20:0] dat_s1;
    logic [20:0] dat_s2;
    logic [20:0] dat_s3;
    logic clk_f;
    logic sel_f;
    logic slp_f;
    logic [7:0] per_cnt;
    logic [7:0] per_q;
    logic [8:0] acc;
    logic [2:0] slot;
    logic seen;
    logic [17:0] lock_cnt;
    logic locked;
  } lpst_state_t;

  lpst_state_t q;
  lpst_state_t d;
  logic [20:0] pin_word;
  logic clk_agree;
  logic strobe;
  logic asleep;
  logic drive_en;
  logic [17:0] lock_last;

  lpst_lane_if lk ();

  lpst_lane_ser u_ser (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .lk(lk)
  );

  // Word layout sets the lane mapping: red, green, blue, then controls
  assign pin_word = {pixel_valid_i, frame_sync_i, line_sync_i, blue_i, green_i, red_i};
  assign lock_last = 18'(LOCK_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Edge detection on the filtered pixel clock
  always_comb begin
    clk_agree = q.clk_s[1] == q.clk_s[2];
    // Rising edge when select is high, falling when low or open
    strobe = clk_agree && q.clk_s[2] != q.clk_f && q.clk_s[2] == q.sel_f;
    asleep = !q.slp_f;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    d = q;
    // Three-stage samplers; data stages line up with the clock stages
    d.clk_s = {q.clk_s[1:0], pixel_clock_in_i};
    d.sel_s = {q.sel_s[1:0], strobe_edge_select_i};
    d.slp_s = {q.slp_s[1:0], sleep_n_i};
    d.dat_s1 = pin_word;
    d.dat_s2 = q.dat_s1;
    d.dat_s3 = q.dat_s2;
    if (clk_agree) begin
      d.clk_f = q.clk_s[2];
    end
    if (q.sel_s[1] == q.sel_s[2]) begin
      d.sel_f = q.sel_s[2];
    end
    if (q.slp_s[1] == q.slp_s[2]) begin
      d.slp_f = q.slp_s[2];
    end
    if (asleep) begin
      // Sleep aborts everything and forces a fresh lock on release
      d.per_cnt = 8'h00;
      d.per_q = 8'h00;
      d.acc = 9'h000;
      d.slot = 3'h0;
      d.seen = 1'b0;
      d.lock_cnt = 18'h00000;
      d.locked = 1'b0;
    end else begin
      // Period measure; per_cnt saturates, but a slow clock wraps the stored period per_q to 0
      if (strobe) begin
        d.per_q = q.per_cnt + 8'h01;
        d.per_cnt = 8'h00;
        d.seen = 1'b1;
      end else if (q.per_cnt != 8'hFF) begin
        d.per_cnt = q.per_cnt + 8'h01;
      end
      // Fractional slot timing: seven slots spread over one period
      if (strobe) begin
        d.acc = 9'h000;
        d.slot = 3'h0;
      end else if (q.slot < lpst_pkg::LAST_SLOT && q.per_q != 8'h00) begin
        d.acc = q.acc + lpst_pkg::SLOT_STEP;
        if (d.acc >= {1'b0, q.per_q}) begin
          d.acc = d.acc - {1'b0, q.per_q};
          d.slot = q.slot + 3'h1;
        end
      end
      // Lock wait only starts once the clock is seen
      if (q.seen && !q.locked) begin
        if (q.lock_cnt == lock_last) begin
          d.locked = 1'b1;
        end else begin
          d.lock_cnt = q.lock_cnt + 18'h00001;
        end
      end
    end
  end

  // State register
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serializer control
  always_comb begin
    lk.clear = asleep;
    lk.load = strobe && !asleep;
    lk.word = q.dat_s3;
    lk.slot_en = d.slot != q.slot && !strobe;
  end

  // Pin-level sleep gates the drivers directly: the sampler is too slow for 100 ns
  assign drive_en = q.locked && sleep_n_i;

  // Output pairs
  always_comb begin
    serial_lane_p_o = drive_en ? lk.lanes : 3'h0;
    serial_lane_n_o = drive_en ? ~lk.lanes : 3'h0;
    serial_lane_oe_o = {3{drive_en}};
    forwarded_clock_p_o = drive_en && lk.clk_lane;
    forwarded_clock_n_o = drive_en && !lk.clk_lane;
    forwarded_clock_oe_o = drive_en;
    locked_o = q.locked;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_sleep_hiz;
    @(posedge clk_i) disable iff (!nrst_i)
    !sleep_n_i |-> serial_lane_oe_o == 3'h0 && !forwarded_clock_oe_o;
  endproperty
  a_sleep_hiz: assert property (p_sleep_hiz) else $error("outputs driven in sleep");

  property p_sleep_abort;
    @(posedge clk_i) disable iff (!nrst_i)
    $fell(q.slp_f) |=> !q.locked && q.slot == 3'h0 && u_ser.q.slot_q == 3'h0
      && u_ser.q.lanes_q == 3'h0 && !u_ser.q.clk_q;
  endproperty
  a_sleep_abort: assert property (p_sleep_abort) else $error("transfer not aborted");

  property p_lock_time;
    @(posedge clk_i) disable iff (!nrst_i)
    $rose(q.locked) |-> $past(q.lock_cnt) == lock_last && $past(q.seen);
  endproperty
  a_lock_time: assert property (p_lock_time) else $error("lock too early");

  property p_inactive_before_lock;
    @(posedge clk_i) disable iff (!nrst_i)
    !q.locked |-> serial_lane_p_o == 3'h0 && !forwarded_clock_p_o && !forwarded_clock_oe_o;
  endproperty
  a_inactive_before_lock: assert property (p_inactive_before_lock) else $error("toggling unlocked");

  property p_edge_sel;
    @(posedge clk_i) disable iff (!nrst_i)
    lk.load |-> q.clk_s[2] == q.sel_f && q.clk_f != q.clk_s[2] && q.clk_s[1] == q.clk_s[2];
  endproperty
  a_edge_sel: assert property (p_edge_sel) else $error("wrong capture edge");

  property p_slot_bound;
    @(posedge clk_i) disable iff (!nrst_i)
    q.slot <= 3'h6 && q.acc < 9'h107;
  endproperty
  a_slot_bound: assert property (p_slot_bound) else $error("slot out of range");

  property p_slot_start;
    @(posedge clk_i) disable iff (!nrst_i)
    strobe && !asleep |=> q.slot == 3'h0 && q.acc == 9'h000 && u_ser.q.slot_q == 3'h0;
  endproperty
  a_slot_start: assert property (p_slot_start) else $error("period did not restart");

  property p_sleep_fast;
    @(posedge clk_i) disable iff (!nrst_i)
    $fell(sleep_n_i) |-> !drive_en ##[1:6] (!q.locked || sleep_n_i);
  endproperty
  a_sleep_fast: assert property (p_sleep_fast) else $error("sleep too slow");
endmodule
`default_nettype wire

// ---- bench/lpst_ctrl_model.sv ----
// Graphics controller model: pixel clock and 21 parallel lines
`timescale 1ns/100ps
`default_nettype none
module lpst_ctrl_model (
  // Control from the bench
  input wire logic run_i,
  input wire logic [20:0] word_fall_i,
  input wire logic [20:0] word_rise_i,
  // Pixel pins
  output logic pclk_o,
  output logic [20:0] data_o
);
  ////////////////////////////////////////////////////////////////////////////
  // 400 ns clock, running while run_i is high, with an odd start phase against the system clock.
  // Each word stands a half period centred on the edge that should take it,
  // so a wrong strobe edge picks up the other word.
  initial begin
    pclk_o = 1'b0;
    data_o = 21'h000000;
    #13;
    forever begin
      if (run_i) begin // Live clock while enabled
        pclk_o = 1'b1;
        #100 data_o = word_fall_i; // All 21 lines each cycle
        #100 pclk_o = 1'b0;
        #100 data_o = word_rise_i;
        #100;
      end else begin
        pclk_o = 1'b0; // A stopped clock stands low
        #100;
      end
    end
  end
endmodule
`default_nettype wire

// ---- bench/tb_lpst_top.sv ----
// Self-checking bench for the pixel serializer transmitter
`timescale 1ns/100ps
`default_nettype none
module tb_lpst_top;
  typedef struct packed {logic sel; logic [20:0] wf; logic [20:0] wr; logic [20:0] ew;} lpst_row_t;
  localparam int LOCK = 50;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic run = 1'b1;
  logic sel = 1'b0;
  logic sleep_n = 1'b0;
  logic [20:0] wf = 21'h000000;
  logic [20:0] wr = 21'h000000;
  logic pclk;
  logic [20:0] data;
  logic [2:0] lane_p, lane_n, lane_oe;
  logic fwd_p, fwd_n, fwd_oe, locked;
  int err_count = 0;
  int comparisons = 0;
  int cyc = 0;
  logic [3:0] hist [0:5];
  logic [3:0] smp [0:6];
  logic [2:0] since_fall = 3'h0;
  logic [20:0] dec_word = 21'h000000;
  logic [6:0] dec_clk = 7'h00;
  lpst_row_t rows [10] = '{
    '{1'b0, 21'h000000, 21'h1FFFFF, 21'h000000}, '{1'b0, 21'h1FFFFF, 21'h000000, 21'h1FFFFF},
    '{1'b1, 21'h0AAAAA, 21'h155555, 21'h155555}, '{1'b1, 21'h000000, 21'h00003F, 21'h00003F},
    '{1'b0, 21'h000FC0, 21'h000000, 21'h000FC0}, '{1'b0, 21'h03F000, 21'h000000, 21'h03F000},
    '{1'b0, 21'h040000, 21'h000000, 21'h040000}, '{1'b1, 21'h000000, 21'h080000, 21'h080000},
    '{1'b0, 21'h100000, 21'h000000, 21'h100000}, '{1'b0, 21'h123456, 21'h0EDCBA, 21'h123456}};

  // 20 MHz system clock
  always #25 clk_i = ~clk_i;

  ////////////////////////////////////////////////////////////////////////////
  lpst_ctrl_model i_lpst_ctrl_model (.run_i(run), .word_fall_i(wf), .word_rise_i(wr),
    .pclk_o(pclk), .data_o(data));

  // Short lock wait keeps the run brief; checks below use the same figure
  lpst_top #(.LOCK_CYCLES(LOCK)) i_lpst_top (.clk_i(clk_i), .nrst_i(nrst_i),
    .pixel_clock_in_i(pclk), .red_i(data[5:0]), .green_i(data[11:6]), .blue_i(data[17:12]),
    .line_sync_i(data[18]), .frame_sync_i(data[19]), .pixel_valid_i(data[20]),
    .strobe_edge_select_i(sel), .sleep_n_i(sleep_n), .serial_lane_p_o(lane_p),
    .serial_lane_n_o(lane_n), .serial_lane_oe_o(lane_oe), .forwarded_clock_p_o(fwd_p),
    .forwarded_clock_n_o(fwd_n), .forwarded_clock_oe_o(fwd_oe), .locked_o(locked));

  ////////////////////////////////////////////////////////////////////////////
  // Receiver: the forwarded clock falls at slot 2; slot k is sampled on the
  // last cycle it stands, which assumes eight system cycles per pixel period
  always @(posedge clk_i) begin
    if (since_fall == 3'h4) begin
      for (int s = 0; s < 6; s++) smp[s] = hist[5 - s];
      smp[6] = {fwd_p, lane_p};
      for (int s = 0; s < 7; s++) begin
        dec_clk[s] = smp[s][3];
        for (int l = 0; l < 3; l++) dec_word[l * 7 + s] = smp[s][l];
      end
    end
    if (hist[0][3] === 1'b1 && fwd_p === 1'b0 && fwd_oe === 1'b1) since_fall <= 3'h1;
    else if (since_fall != 3'h0) since_fall <= (since_fall == 3'h4) ? 3'h0 : since_fall + 3'h1;
    for (int i = 5; i > 0; i--) hist[i] <= hist[i - 1];
    hist[0] <= {fwd_p, lane_p};
  end

  // Hang guard, well above the expected length of the run
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      err_count++;
      tally_and_finish();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [20:0] exp, input logic [20:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  // Releases sleep with the clock live and waits for the lock period
  task automatic wake_and_lock();
    int n;
    n = 0;
    @(negedge clk_i);
    sleep_n = 1'b1;
    wait_clk(LOCK - 10);
    check("quiet while locking", 21'h0, {16'h0, locked, fwd_oe, lane_oe});
    while (locked !== 1'b1 && n < 100) begin
      wait_clk(1);
      n++;
    end
    check("locked", 21'h1, {20'h0, locked}); // Lock after the wait
    wait_clk(2);
    check("drivers on", 21'hF, {17'h0, fwd_oe, lane_oe}); // Pair beside lanes
  endtask

  task automatic run_row(input lpst_row_t r);
    @(negedge clk_i);
    sel = r.sel;
    wf = r.wf;
    wr = r.wr;
    wait_clk(32);
    check("lane word", r.ew, dec_word);
    check("clock shape", {14'h0, lpst_pkg::CLK_PATTERN}, {14'h0, dec_clk});
    check("lane pair", {18'h0, ~lane_p}, {18'h0, lane_n}); // Complement pair
    check("clock pair", {20'h0, ~fwd_p}, {20'h0, fwd_n}); // Complement pair
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence: reset, table, then sleep abort and clock restart
  initial begin
    wait_clk(5);
    check("reset outputs", 21'h0, {12'h0, locked, fwd_oe, lane_oe, fwd_p, lane_p});
    nrst_i = 1'b1;
    wait_clk(3);
    wake_and_lock(); // Clock already live before enable
    foreach (rows[i]) run_row(rows[i]);
    // Sleep in mid-transfer must drop every driver at once
    @(negedge clk_i);
    sleep_n = 1'b0;
    #1;
    check("sleep drivers", 21'h0, {17'h0, fwd_oe, lane_oe}); // Within 100 ns
    wait_clk(5);
    check("sleep state", 21'h0, {17'h0, locked, fwd_p, fwd_n, fwd_oe});
    // Clock stop only while asleep, restart before release
    run = 1'b0;
    wait_clk(20);
    run = 1'b1;
    wait_clk(16);
    wake_and_lock(); // Fresh lock wait after restart
    run_row('{1'b0, 21'h0F0F0F, 21'h10F0F0, 21'h0F0F0F});
    tally_and_finish();
  end
endmodule
`default_nettype wire
